//--- rtl/icu_capture_top.sv
`timescale 1ns/100ps
module icu_capture_top
   import icu_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic channel_a_pin,
   input wire logic route_pin_primary,
   input wire logic route_pin_alternate,
   input wire logic channel_b_pin_route_fuse,
   input wire logic [3:0] chan_a_mode_field,
   input wire logic [3:0] chan_b_mode_field,
   input wire logic timer_sel_a_three,
   input wire logic timer_sel_b_three,
   input wire logic [15:0] timer_one_count,
   input wire logic [15:0] timer_three_count,
   input wire logic chan_a_compare_match,
   input wire logic chan_b_compare_match,
   input wire logic adc_enable,
   input wire logic chan_a_irq_flag_clr,
   input wire logic chan_b_irq_flag_clr,
   output logic [7:0] cap_a_high_byte,
   output logic [7:0] cap_a_low_byte,
   output logic [7:0] cap_b_high_byte,
   output logic [7:0] cap_b_low_byte,
   output logic chan_a_irq_flag,
   output logic chan_b_irq_flag,
   output logic timer_one_reset,
   output logic timer_three_reset,
   output logic adc_start_req,
   output logic pwm_shared_timer_two
);

   typedef struct packed {
      logic [15:0] cap_a;
      logic [15:0] cap_b;
      logic flag_a;
      logic flag_b;
      logic t1_rst;
      logic t3_rst;
      logic adc_start;
      logic pwm_shared;
   } icu_top_t;

   icu_top_t st_reg;
   icu_top_t st_next;

   logic pin_b;
   logic rise_a;
   logic fall_a;
   logic rise_b;
   logic fall_b;
   logic evt_a;
   logic evt_b;
   logic sev_a;
   logic sev_b;
   logic [15:0] base_a;
   logic [15:0] base_b;

   // R01 fuse routes channel b to primary pin when set
   assign pin_b = channel_b_pin_route_fuse ? route_pin_primary : route_pin_alternate;

   icu_pin_sync u_sync_a (
      .core_clk (core_clk),
      .rst (rst),
      .pin_in (channel_a_pin),
      .rise (rise_a),
      .fall (fall_a)
   );

   icu_pin_sync u_sync_b (
      .core_clk (core_clk),
      .rst (rst),
      .pin_in (pin_b),
      .rise (rise_b),
      .fall (fall_b)
   );

   // R04 mode field picks the qualifying edge
   icu_edge_prescaler u_presc_a (
      .core_clk (core_clk),
      .rst (rst),
      .mode (chan_a_mode_field),
      .rise (rise_a),
      .fall (fall_a),
      .cap_event (evt_a)
   );

   // R05 mode decode lives in the prescaler
   icu_edge_prescaler u_presc_b (
      .core_clk (core_clk),
      .rst (rst),
      .mode (chan_b_mode_field),
      .rise (rise_b),
      .fall (fall_b),
      .cap_event (evt_b)
   );

   // R09 independent time base per channel
   assign base_a = icu_time_base(timer_sel_a_three, timer_one_count, timer_three_count);
   assign base_b = icu_time_base(timer_sel_b_three, timer_one_count, timer_three_count);

   // match only counts as a trigger in special event mode
   assign sev_a = (chan_a_mode_field == ICU_MODE_SPECIAL) && chan_a_compare_match;
   assign sev_b = (chan_b_mode_field == ICU_MODE_SPECIAL) && chan_b_compare_match;

   always_comb
   begin
      st_next = st_reg;

      // R03 copy selected timer on event
      if (evt_a)
      begin
         // R08 overwrite without overrun check
         st_next.cap_a = base_a;
      end
      // R03 channel b capture
      if (evt_b)
      begin
         // R08 unread value simply lost
         st_next.cap_b = base_b;
      end

      // R16 mode change can flag early through a leftover prescaler count
      // R07 flag set wins over software clear
      st_next.flag_a = (st_reg.flag_a & ~chan_a_irq_flag_clr) | evt_a
         | (icu_is_compare(chan_a_mode_field) & chan_a_compare_match);
      // R07 hardware never clears flag
      st_next.flag_b = (st_reg.flag_b & ~chan_b_irq_flag_clr) | evt_b
         | (icu_is_compare(chan_b_mode_field) & chan_b_compare_match);

      // R10 trigger resets own time base
      st_next.t1_rst = (sev_a & ~timer_sel_a_three) | (sev_b & ~timer_sel_b_three);
      st_next.t3_rst = (sev_a & timer_sel_a_three) | (sev_b & timer_sel_b_three);

      // R11 channel b trigger may start conversion
      // R12 channel a trigger never feeds conversion
      st_next.adc_start = sev_b & adc_enable;

      // R13 both pulse-width channels share timer two
      st_next.pwm_shared = icu_is_pwm(chan_a_mode_field) & icu_is_pwm(chan_b_mode_field);
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign cap_a_high_byte = st_reg.cap_a[15:8];
   assign cap_a_low_byte = st_reg.cap_a[7:0];
   assign cap_b_high_byte = st_reg.cap_b[15:8];
   assign cap_b_low_byte = st_reg.cap_b[7:0];
   assign chan_a_irq_flag = st_reg.flag_a;
   assign chan_b_irq_flag = st_reg.flag_b;
   assign timer_one_reset = st_reg.t1_rst;
   assign timer_three_reset = st_reg.t3_rst;
   assign adc_start_req = st_reg.adc_start;
   assign pwm_shared_timer_two = st_reg.pwm_shared;

endmodule

//--- rtl/icu_pkg.sv
// Operation
// R01: channel b pin comes from primary pin when fuse is 1, else alternate.
// R02: software must make the capture pin an input wherever it is routed.
// R03: on a capture event copy the selected 16-bit timer into the capture bytes.
// R04: mode field bits 3:0 select falling, rising, 4th rising or 16th rising edge.
// R05: modes 0100 falling, 0101 rising, 0110 every 4th, 0111 every 16th rising.
// R06: mode 0000 turns the channel off and clears its internal state.
// R07: each capture sets the channel flag; only software clears it.
// R08: a new capture overwrites an unread value with no overrun indication.
// R09: each capturing channel picks timer one or three through its own select bit.
// R10: a compare special event trigger resets the channel's own time base.
// R11: channel b special event trigger also starts a conversion when converter enabled.
// R12: channel a special event trigger only resets its timer, never starts conversion.
// R13: two channels both in pulse-width mode share timer two.
// R14: the capture time base must run as timer or synchronised counter.
// R15: the pin level is watched even while the pin is driven as output.
// R16: a mode change may set the flag; software masks it then clears it.
// R17: the prescaler counter is held clear when off or not capturing.
// R18: switching between capture prescalers keeps the counter running.
// R19: software should write zero to the mode before a new prescaler mode.
// R20: the pin passes a two-stage synchroniser before edge detection.
// R21: prescaler counts rising edges only and captures on its wrap.
package icu_pkg;

   localparam logic [3:0] ICU_MODE_OFF = 4'h0;
   localparam logic [3:0] ICU_MODE_TOGGLE = 4'h2;
   localparam logic [3:0] ICU_MODE_FALL = 4'h4;
   localparam logic [3:0] ICU_MODE_RISE = 4'h5;
   localparam logic [3:0] ICU_MODE_DIV4 = 4'h6;
   localparam logic [3:0] ICU_MODE_DIV16 = 4'h7;
   localparam logic [3:0] ICU_MODE_SPECIAL = 4'hB;
   localparam logic [1:0] ICU_GRP_CAPTURE = 2'h1;
   localparam logic [1:0] ICU_GRP_COMPARE = 2'h2;
   localparam logic [1:0] ICU_GRP_PWM = 2'h3;
   localparam int ICU_MODE_MSB = 3;
   localparam int ICU_MODE_LSB = 0;
   localparam int ICU_FLAG_BIT = 0;
   localparam logic [3:0] ICU_PRESC_TERM_4 = 4'h3;
   localparam logic [3:0] ICU_PRESC_TERM_16 = 4'hF;
   localparam logic [3:0] ICU_PRESC_RESET = 4'h0;
   localparam logic [15:0] ICU_CAP_RESET = 16'h0000;

   function automatic logic icu_is_capture(input logic [3:0] mode);
      return mode[3:2] == ICU_GRP_CAPTURE;
   endfunction

   function automatic logic icu_is_compare(input logic [3:0] mode);
      return (mode == ICU_MODE_TOGGLE) || (mode[3:2] == ICU_GRP_COMPARE);
   endfunction

   function automatic logic icu_is_pwm(input logic [3:0] mode);
      return mode[3:2] == ICU_GRP_PWM;
   endfunction

   // timer three chosen when the select bit is set
   function automatic logic [15:0] icu_time_base(input logic sel_three,
      input logic [15:0] t_one, input logic [15:0] t_three);
      return sel_three ? t_three : t_one;
   endfunction

endpackage

//--- rtl/icu_pin_sync.sv
`timescale 1ns/100ps
module icu_pin_sync
   import icu_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin_in,
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rise;
      logic fall;
   } icu_sync_t;

   icu_sync_t st_reg;
   icu_sync_t st_next;

   always_comb
   begin
      st_next = st_reg;
      // R20 two-stage synchroniser
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // R15 level-based edges
      st_next.rise = st_reg.s2 & ~st_reg.s3;
      st_next.fall = ~st_reg.s2 & st_reg.s3;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rise = st_reg.rise;
   assign fall = st_reg.fall;

endmodule

//--- rtl/icu_edge_prescaler.sv
`timescale 1ns/100ps
module icu_edge_prescaler
   import icu_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] mode,
   input wire logic rise,
   input wire logic fall,
   output logic cap_event
);

   typedef struct packed {
      logic [3:0] cnt;
      logic evt;
   } icu_presc_t;

   icu_presc_t st_reg;
   icu_presc_t st_next;
   logic [3:0] term;

   always_comb
   begin
      st_next = st_reg;
      st_next.evt = 1'b0;
      term = (mode == ICU_MODE_DIV4) ? ICU_PRESC_TERM_4 : ICU_PRESC_TERM_16;
      // R06 off clears state
      // R17 held clear unless capturing
      if (!icu_is_capture(mode))
      begin
         st_next.cnt = ICU_PRESC_RESET;
      end
      else
      begin
         case (mode)
            ICU_MODE_FALL:
               st_next.evt = fall;
            ICU_MODE_RISE:
               st_next.evt = rise;
            default:
               // R21 count rising, capture on wrap
               if (rise)
               begin
                  // R18 masked compare, leftover count gives early capture
                  if ((st_reg.cnt & term) == term)
                  begin
                     st_next.evt = 1'b1;
                     st_next.cnt = ICU_PRESC_RESET;
                  end
                  else
                  begin
                     st_next.cnt = st_reg.cnt + 4'h1;
                  end
               end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign cap_event = st_reg.evt;

endmodule

//--- verification/icu_monitor.sv
`timescale 1ns/100ps
module icu_monitor
   import icu_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] chan_a_mode_field,
   input wire logic [3:0] chan_b_mode_field,
   input wire logic timer_sel_a_three,
   input wire logic timer_sel_b_three,
   input wire logic chan_a_compare_match,
   input wire logic chan_b_compare_match,
   input wire logic adc_enable,
   input wire logic chan_a_irq_flag_clr,
   input wire logic chan_b_irq_flag_clr,
   input wire logic [7:0] cap_a_high_byte,
   input wire logic [7:0] cap_a_low_byte,
   input wire logic chan_a_irq_flag,
   input wire logic chan_b_irq_flag,
   input wire logic timer_one_reset,
   input wire logic timer_three_reset,
   input wire logic adc_start_req,
   input wire logic pwm_shared_timer_two
);
   logic trig_a;
   logic trig_b;
   assign trig_a = chan_a_mode_field == ICU_MODE_SPECIAL && chan_a_compare_match;
   assign trig_b = chan_b_mode_field == ICU_MODE_SPECIAL && chan_b_compare_match;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_flag_a;
      chan_a_irq_flag && !chan_a_irq_flag_clr |=> chan_a_irq_flag;
   endproperty
   a_flag_a: assert property (p_flag_a) else $error("flag a lost");
   property p_flag_b;
      chan_b_irq_flag && !chan_b_irq_flag_clr |=> chan_b_irq_flag;
   endproperty
   a_flag_b: assert property (p_flag_b) else $error("flag b lost");
   property p_cap_flag;
      !$stable({cap_a_high_byte, cap_a_low_byte}) |-> chan_a_irq_flag;
   endproperty
   a_cap_flag: assert property (p_cap_flag) else $error("capture without flag");
   property p_t1_rst;
      trig_a && !timer_sel_a_three |=> timer_one_reset;
   endproperty
   a_t1_rst: assert property (p_t1_rst) else $error("timer one not reset");
   property p_t3_cause;
      timer_three_reset |-> $past(trig_a && timer_sel_a_three || trig_b && timer_sel_b_three);
   endproperty
   a_t3_cause: assert property (p_t3_cause) else $error("stray timer three reset");
   property p_adc_go;
      trig_b && adc_enable |=> adc_start_req;
   endproperty
   a_adc_go: assert property (p_adc_go) else $error("no conversion start");
   property p_adc_cause;
      adc_start_req |-> $past(trig_b && adc_enable);
   endproperty
   a_adc_cause: assert property (p_adc_cause) else $error("stray conversion start");
   property p_pwm;
      chan_a_mode_field[3:2] == ICU_GRP_PWM && chan_b_mode_field[3:2] == ICU_GRP_PWM
         |=> pwm_shared_timer_two;
   endproperty
   a_pwm: assert property (p_pwm) else $error("timer two not shared");
   c_capture: cover property ($rose(chan_a_irq_flag));
   c_adc: cover property (adc_start_req);
   c_pwm: cover property (pwm_shared_timer_two);
endmodule
bind icu_capture_top icu_monitor mon (.core_clk(core_clk), .rst(rst),
   .chan_a_mode_field(chan_a_mode_field), .chan_b_mode_field(chan_b_mode_field),
   .timer_sel_a_three(timer_sel_a_three), .timer_sel_b_three(timer_sel_b_three),
   .chan_a_compare_match(chan_a_compare_match), .chan_b_compare_match(chan_b_compare_match),
   .adc_enable(adc_enable), .chan_a_irq_flag_clr(chan_a_irq_flag_clr),
   .chan_b_irq_flag_clr(chan_b_irq_flag_clr), .cap_a_high_byte(cap_a_high_byte),
   .cap_a_low_byte(cap_a_low_byte), .chan_a_irq_flag(chan_a_irq_flag),
   .chan_b_irq_flag(chan_b_irq_flag), .timer_one_reset(timer_one_reset),
   .timer_three_reset(timer_three_reset), .adc_start_req(adc_start_req),
   .pwm_shared_timer_two(pwm_shared_timer_two));

//--- verification/icu_pin_model.sv
`timescale 1ns/100ps
module icu_pin_model
(
   input wire logic core_clk,
   output logic [2:0] pin_levels
);
   initial pin_levels = 3'h0;
   // levels hold two cycles so the synchroniser sees each one
   task automatic set_pin(input int ch, input logic lvl);
      @(posedge core_clk);
      #1;
      pin_levels[ch] = lvl;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
endmodule

//--- verification/icu_capture_top_test.sv
`timescale 1ns/100ps
module icu_capture_top_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic fuse = 1'b1;
   logic adc_en = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [3:0] ma = 4'h0;
   logic [3:0] mb = 4'h0;
   logic [15:0] t1 = 16'h0000;
   logic [15:0] t3 = 16'h0000;
   logic [1:0] mt = 2'h0;
   logic [1:0] clr = 2'h0;
   wire [2:0] pins;
   wire [7:0] ah, al, bh, bl;
   wire [1:0] flg;
   wire t1r, t3r, adc, pwm;
   int errors = 0;
   int checks = 0;
   int k;
   always #2 core_clk = ~core_clk;
   icu_pin_model src (.core_clk(core_clk), .pin_levels(pins));
   icu_capture_top dut (.core_clk(core_clk), .rst(rst), .channel_a_pin(pins[0]),
      .route_pin_primary(pins[1]), .route_pin_alternate(pins[2]),
      .channel_b_pin_route_fuse(fuse), .chan_a_mode_field(ma), .chan_b_mode_field(mb),
      .timer_sel_a_three(sel[0]), .timer_sel_b_three(sel[1]), .timer_one_count(t1),
      .timer_three_count(t3), .chan_a_compare_match(mt[0]), .chan_b_compare_match(mt[1]),
      .adc_enable(adc_en), .chan_a_irq_flag_clr(clr[0]), .chan_b_irq_flag_clr(clr[1]),
      .cap_a_high_byte(ah), .cap_a_low_byte(al), .cap_b_high_byte(bh), .cap_b_low_byte(bl),
      .chan_a_irq_flag(flg[0]), .chan_b_irq_flag(flg[1]), .timer_one_reset(t1r),
      .timer_three_reset(t3r), .adc_start_req(adc), .pwm_shared_timer_two(pwm));
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rise(input int ch, input int n);
      repeat (n)
      begin
         src.set_pin(ch, 1'b0);
         src.set_pin(ch, 1'b1);
      end
   endtask
   task automatic clear();
      clr = 2'h3;
      tick(1);
      clr = 2'h0;
   endtask
   task automatic give_verdict();
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      tick(3);
      rst = 1'b0;
      ma = 4'h5;
      // timers hold fixed values set by the bench
      t1 = 16'h1234;
      t3 = 16'h9abc;
      rise(0, 1);
      tick(4);
      chk("cap_a", 16'h1234, {ah, al});
      chk("flag_a", 16'h0001, {15'h0, flg[0]});
      clear();
      chk("flag_a", 16'h0000, {15'h0, flg[0]});
      t1 = 16'h5678;
      rise(0, 1);
      tick(4);
      chk("cap_a", 16'h5678, {ah, al});
      ma = 4'h4;
      sel = 2'h1;
      src.set_pin(0, 1'b0);
      tick(4);
      chk("cap_a", 16'h9abc, {ah, al});
      ma = 4'h0;
      clear();
      rise(0, 1);
      tick(4);
      chk("flag_a", 16'h0000, {15'h0, flg[0]});
      for (k = 0; k < 2; k++)
      begin
         fuse = (k == 0);
         mb = 4'h0;
         tick(1);
         mb = (k == 0) ? 4'h6 : 4'h7;
         clear();
         rise(k + 1, k * 12 + 3);
         tick(4);
         chk("flag_b", 16'h0000, {15'h0, flg[1]});
         t1 = {8'ha0, 8'(k)};
         rise(k + 1, 1);
         tick(4);
         chk("cap_b", {8'ha0, 8'(k)}, {bh, bl});
      end
      clear();
      rise(2, 7);
      mb = 4'h6;
      rise(2, 1);
      tick(4);
      chk("flag_b", 16'h0001, {15'h0, flg[1]});
      adc_en = 1'b1;
      ma = 4'hb;
      mb = 4'hb;
      sel = 2'h2;
      mt = 2'h1;
      tick(1);
      mt = 2'h0;
      chk("trigger", 16'h0004, {13'h0, t1r, t3r, adc});
      chk("flag_a", 16'h0001, {15'h0, flg[0]});
      mt = 2'h2;
      tick(1);
      mt = 2'h0;
      chk("trigger", 16'h0003, {13'h0, t1r, t3r, adc});
      // toggle compare mode also flags on a match
      ma = 4'h2;
      clear();
      mt = 2'h1;
      tick(1);
      mt = 2'h0;
      chk("flag_a", 16'h0001, {15'h0, flg[0]});
      ma = 4'hc;
      mb = 4'hf;
      tick(2);
      chk("pwm", 16'h0001, {15'h0, pwm});
      give_verdict();
   end
endmodule
